// ===== hw/supervisor_ce_gate.sv
// Chip-enable gating for the memory behind the supervisor
`timescale 1ns/100ps
`include "supervisor_defines.svh"
module supervisor_ce_gate
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_reset_active,
  input wire logic i_supply_ok,
  input wire logic i_ce_n_sync,
  output logic o_ce_n
);
  typedef struct packed
  {
    supervisor_pkg::ce_state_e state;
    logic [`CE_CNT_W-1:0] cnt;
  } ce_s;
  ce_s st_reg;
  ce_s st_next;
  // ==========================================================
  // Gate state: pass while out of reset, brief hold of an active cycle on entry
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg.state)
      supervisor_pkg::CE_PASS:
      begin
        // Supply loss enters the hold at once, in the same cycle that reset is registered
        if (i_reset_active || !i_supply_ok)
        begin
          st_next.cnt = '0;
          // Active access finishes instead of being cut mid-cycle
          st_next.state = i_ce_n_sync ? supervisor_pkg::CE_BLOCK : supervisor_pkg::CE_HOLD; // R9
        end
      end
      supervisor_pkg::CE_HOLD:
      begin
        st_next.cnt = st_reg.cnt + 8'h01;
        if (i_ce_n_sync || (st_reg.cnt >= 8'(`CE_HOLD_CYCLES - 1)))
        begin
          st_next.state = supervisor_pkg::CE_BLOCK; // R9
        end
      end
      supervisor_pkg::CE_BLOCK:
      begin
        if (!i_reset_active)
        begin
          st_next.state = supervisor_pkg::CE_PASS;
        end
      end
    endcase
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      st_reg <= '{state: supervisor_pkg::CE_BLOCK, cnt: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  // Pass and hold both follow the input, so an access running into reset never glitches high
  // Limitation: output lags the pin by the synchroniser
  assign o_ce_n = i_ce_n_sync | (st_reg.state == supervisor_pkg::CE_BLOCK); // R8
  AST_CE_BLOCKED: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (st_reg.state == supervisor_pkg::CE_BLOCK) |-> o_ce_n) else $error("ce passed while blocked"); // R8
  AST_CE_HOLD_LIMIT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(st_reg.state == supervisor_pkg::CE_HOLD) |-> ##[1:150] (st_reg.state != supervisor_pkg::CE_HOLD))
    else $error("ce hold too long"); // R9
  COV_CE_HOLD: cover property (@(posedge i_sys_clk) st_reg.state == supervisor_pkg::CE_HOLD);
endmodule

// ===== hw/supervisor_defines.svh
// Timing constants and counter widths for the supervisor block
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH
// ==========================================================
// Clock and internal timebase
`define SYS_CLK_HZ 10000000
`define INT_TICK_HZ 10240
`define INT_TICK_DIV (`SYS_CLK_HZ / `INT_TICK_HZ)
// ==========================================================
// Periods in milliseconds and in timebase ticks
`define WD_SLOW_MS 1600
`define WD_FAST_MS 100
`define RST_MS 200
`define INT_WD_SLOW_TICKS 16384
`define INT_WD_FAST_TICKS 1024
`define INT_RST_TICKS 2048
`define EXT_WD_NORMAL_TICKS 1024
`define EXT_WD_AFTER_RST_TICKS 4096
`define EXT_RST_TICKS 2048
// ==========================================================
// Chip-enable hold on entry to reset, in system cycles (15 us, rounded down)
`define CE_HOLD_US 15
`define CE_HOLD_CYCLES ((`CE_HOLD_US * (`SYS_CLK_HZ / 1000000)))
`define CNT_W 16
`define CE_CNT_W 8
`endif

// ===== hw/supervisor_pkg.sv
// Types shared by the supervisor block
package supervisor_pkg;
  typedef enum logic [1:0] {WD_OFF, WD_ARMED, WD_FAULT} wd_state_e;
  typedef enum logic [1:0] {CE_PASS, CE_HOLD, CE_BLOCK} ce_state_e;
endpackage

// ===== hw/supervisor_watchdog.sv
// Reset generator, watchdog, chip-enable gate and status flags
// How it works
// (R1) Stuck activity past timeout drives fault low and pulses both resets.
// (R2) Fault stays low until the next activity transition.
// (R3) Mid-level activity input disables watchdog, fault held high.
// (R4) Active-low reset low whenever supply below threshold.
// (R5) Reset held for reset timeout after supply recovers.
// (R6) Active-high reset is always the inverse of active-low reset.
// (R7) Undervoltage flag follows supply flag without delay.
// (R8) Gated chip-enable low only with input low and supply good; the code also passes it low during the R9 hold.
// (R9) Active chip-enable held until input high or 15 us, then blocked.
// (R10) Select high or floating uses the internal oscillator.
// (R11) Internal oscillator: timebase input level picks fast or slow timeout.
// (R12) Select low takes ticks from the timebase input.
// (R13) Backup flag high on backup source, low on main supply.
// (R14) Main chosen above backup and threshold; backup when below both.
// (R15) Power-fail flag follows comparator, affecting nothing else.
// (R16) Internal: fast 100ms normal, 1.6s after reset; floating 1.6s both.
// (R17) External: 1024 normal, 4096 after reset, 2048 reset ticks.
// (R18) Watchdog off below threshold or on backup, fault high.
// (R19) Stuck activity repeats reset pulses each watchdog period.
// (R20) Periods counted in timebase ticks; watchdog restarts at reset release.
`timescale 1ns/100ps
`include "supervisor_defines.svh"
module supervisor_watchdog
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_supply_ok,
  input wire logic i_main_above_backup,
  input wire logic i_powerfail_sense_low,
  input wire logic i_activity_high,
  input wire logic i_activity_low,
  input wire logic i_timebase_select,
  input wire logic i_timebase_input,
  input wire logic i_timebase_floating,
  input wire logic i_ce_n,
  output logic o_reset_n,
  output logic o_reset,
  output logic o_watchdog_fault_out,
  output logic o_undervoltage_n,
  output logic o_ce_n,
  output logic o_backup_active_flag,
  output logic o_powerfail_flag
);
  localparam int SYNC_W = 9;
  typedef struct packed
  {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic tb_prev;
    logic [`CNT_W-1:0] div;
    logic act_prev;
    logic act_mid_prev;
    supervisor_pkg::wd_state_e wd;
    logic [`CNT_W-1:0] wd_cnt;
    logic after_rst;
    logic [`CNT_W-1:0] rst_cnt;
    logic rst_active;
    logic backup;
    logic pf_n;
    logic uv_n;
  } sup_s;
  sup_s st_reg;
  sup_s st_next;
  logic [SYNC_W-1:0] pins;
  logic supply_ok, main_above, pf_low, act_hi, act_lo, tb_sel, tb_in, tb_float, ce_n_s;
  logic tick, act_mid, act_level, act_edge, wd_enable, wd_expire;
  logic [`CNT_W-1:0] wd_limit;
  logic [`CNT_W-1:0] rst_limit;
  // ==========================================================
  // Pin synchronisers
  assign pins = {i_ce_n, i_timebase_floating, i_timebase_input, i_timebase_select,
                 i_activity_low, i_activity_high, i_powerfail_sense_low, i_main_above_backup, i_supply_ok};
  assign {ce_n_s, tb_float, tb_in, tb_sel, act_lo, act_hi, pf_low, main_above, supply_ok} = st_reg.s2;
  // ==========================================================
  // Timebase and period selection
  always_comb
  begin
    act_mid = !act_hi && !act_lo;
    act_level = act_hi;
    act_edge = !act_mid && !st_reg.act_mid_prev && (act_level != st_reg.act_prev);
    wd_enable = supply_ok && !st_reg.backup && !act_mid; // R3 R18
    if (!tb_sel)
    begin
      // Ticks from the external timebase rising edge
      tick = tb_in && !st_reg.tb_prev; // R12
      wd_limit = st_reg.after_rst ? 16'(`EXT_WD_AFTER_RST_TICKS) : 16'(`EXT_WD_NORMAL_TICKS); // R17
      rst_limit = 16'(`EXT_RST_TICKS); // R17
    end
    else
    begin
      tick = (st_reg.div == 16'(`INT_TICK_DIV - 1)); // R10
      // Low timebase level selects the fast normal timeout
      wd_limit = (!tb_float && !tb_in && !st_reg.after_rst) ? 16'(`INT_WD_FAST_TICKS)
                 : 16'(`INT_WD_SLOW_TICKS); // R11 R16
      rst_limit = 16'(`INT_RST_TICKS);
    end
    wd_expire = tick && (st_reg.wd_cnt >= wd_limit - 16'h0001);
  end
  // ==========================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.tb_prev = tb_in;
    st_next.div = (!tb_sel || tick) ? '0 : st_reg.div + 16'h0001;
    st_next.act_prev = act_level;
    st_next.act_mid_prev = act_mid;
    st_next.uv_n = supply_ok; // R7
    st_next.pf_n = !pf_low; // R15
    // Hysteresis band keeps the present source
    if (main_above && supply_ok)
    begin
      st_next.backup = 1'b0; // R14 R13
    end
    else if (!main_above && !supply_ok)
    begin
      st_next.backup = 1'b1; // R14 R13
    end
    // Reset pulse timing
    if (!supply_ok)
    begin
      st_next.rst_active = 1'b1; // R4
      st_next.rst_cnt = '0;
    end
    else if (st_reg.rst_active)
    begin
      if (tick)
      begin
        st_next.rst_cnt = st_reg.rst_cnt + 16'h0001;
        if (st_reg.rst_cnt >= rst_limit - 16'h0001)
        begin
          st_next.rst_active = 1'b0; // R5
          st_next.after_rst = 1'b1;
        end
      end
    end
    // Watchdog
    unique case (st_reg.wd)
      supervisor_pkg::WD_OFF:
      begin
        st_next.wd_cnt = '0;
        if (wd_enable && !st_reg.rst_active)
        begin
          st_next.wd = supervisor_pkg::WD_ARMED;
        end
      end
      supervisor_pkg::WD_ARMED, supervisor_pkg::WD_FAULT:
      begin
        if (!wd_enable)
        begin
          st_next.wd = supervisor_pkg::WD_OFF; // R18
          st_next.wd_cnt = '0;
        end
        else if (act_edge)
        begin
          // A transition clears the fault even while the reset pulse still runs
          st_next.wd = supervisor_pkg::WD_ARMED; // R2
          st_next.wd_cnt = '0;
          if (!st_reg.rst_active)
          begin
            st_next.after_rst = 1'b0;
          end
        end
        else if (st_reg.rst_active)
        begin
          st_next.wd_cnt = '0; // R20
        end
        else if (wd_expire)
        begin
          st_next.wd = supervisor_pkg::WD_FAULT; // R1
          st_next.wd_cnt = '0;
          st_next.rst_active = 1'b1; // R1 R19
          st_next.rst_cnt = '0;
        end
        else if (tick)
        begin
          st_next.wd_cnt = st_reg.wd_cnt + 16'h0001; // R20
        end
      end
    endcase
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      st_reg <= '{s1: '0, s2: '0, tb_prev: 1'b0, div: '0, act_prev: 1'b0, act_mid_prev: 1'b1,
                  wd: supervisor_pkg::WD_OFF, wd_cnt: '0, after_rst: 1'b1, rst_cnt: '0,
                  rst_active: 1'b1, backup: 1'b0, pf_n: 1'b1, uv_n: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  // ==========================================================
  // Outputs
  assign o_reset_n = !st_reg.rst_active;
  assign o_reset = st_reg.rst_active; // R6
  assign o_watchdog_fault_out = (st_reg.wd != supervisor_pkg::WD_FAULT); // R1 R3
  assign o_undervoltage_n = st_reg.uv_n;
  assign o_backup_active_flag = st_reg.backup;
  assign o_powerfail_flag = st_reg.pf_n;
  supervisor_ce_gate i_supervisor_ce_gate
  (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_reset_active(st_reg.rst_active),
    .i_supply_ok(supply_ok),
    .i_ce_n_sync(ce_n_s),
    .o_ce_n(o_ce_n)
  );
  // ==========================================================
  // Checks
  AST_RESET_INV: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_reset == !o_reset_n) else $error("reset outputs not inverse"); // R6
  AST_UV_RESET: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !supply_ok |=> !o_reset_n) else $error("reset not asserted on undervoltage"); // R4
  AST_UV_FLAG: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_undervoltage_n == $past(supply_ok)) else $error("undervoltage flag wrong"); // R7
  AST_WD_OFF_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!wd_enable) |=> o_watchdog_fault_out) else $error("fault low while disabled"); // R3
  AST_FAULT_RESETS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_watchdog_fault_out) |-> !o_reset_n) else $error("fault without reset"); // R1
  AST_FAULT_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!o_watchdog_fault_out && wd_enable && act_edge) |=> o_watchdog_fault_out)
    else $error("fault not cleared by activity"); // R2
  AST_BACKUP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!main_above && !supply_ok) |=> o_backup_active_flag) else $error("backup not flagged"); // R13
  AST_PF: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_powerfail_flag == !$past(pf_low)) else $error("powerfail flag wrong"); // R15
  COV_FAULT: cover property (@(posedge i_sys_clk) $fell(o_watchdog_fault_out));
  COV_RELEASE: cover property (@(posedge i_sys_clk) $rose(o_reset_n));
  COV_BACKUP: cover property (@(posedge i_sys_clk) $rose(o_backup_active_flag));
endmodule

// ===== sim/sup_host_model.sv
// Host processor model: activity strobe and memory chip-enable
`timescale 1ns/100ps
module sup_host_model
(
  input wire logic i_sys_clk,
  input wire logic i_run,
  input wire logic i_mid,
  input wire logic i_ce_req,
  output logic o_activity_high,
  output logic o_activity_low,
  output logic o_ce_n
);
  logic [5:0] div_reg = 6'h00;
  logic lvl_reg = 1'b0;
  // ======================================
  // Activity strobe
  // Toggles every 64 cycles while running; a stopped host leaves it stuck
  always @(posedge i_sys_clk)
  begin
    div_reg <= div_reg + 6'h01;
    if (i_run && div_reg == 6'h3f)
      lvl_reg <= ~lvl_reg;
  end
  // Unconnected pin reads mid level, so neither decode is high
  assign o_activity_high = !i_mid && lvl_reg;
  assign o_activity_low = !i_mid && !lvl_reg;
  assign o_ce_n = ~i_ce_req;
endmodule

// ===== sim/test_supervisor_watchdog.sv
// Self-checking bench for the supervisor block
`timescale 1ns/100ps
module test_supervisor_watchdog;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sup_ok = 1'b0;
  logic main_hi = 1'b1;
  logic pf_low = 1'b0;
  logic run = 1'b1;
  logic mid = 1'b0;
  logic ce_req = 1'b0;
  logic tb_in = 1'b0;
  logic tb_sel = 1'b0;
  logic tb_float = 1'b0;
  wire act_hi;
  wire act_lo;
  wire ce_in_n;
  wire [6:0] outs;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  string name_q[$];
  int sel_q[$];
  logic exp_q[$];
  // ======================================
  // Instances
  sup_host_model i_sup_host_model (.i_sys_clk(clk), .i_run(run), .i_mid(mid), .i_ce_req(ce_req),
    .o_activity_high(act_hi), .o_activity_low(act_lo), .o_ce_n(ce_in_n));
  // External tick mode keeps the long periods short enough to simulate
  supervisor_watchdog i_supervisor_watchdog (.i_sys_clk(clk), .i_rst(rst), .i_supply_ok(sup_ok),
    .i_main_above_backup(main_hi), .i_powerfail_sense_low(pf_low), .i_activity_high(act_hi),
    .i_activity_low(act_lo), .i_timebase_select(tb_sel), .i_timebase_input(tb_in),
    .i_timebase_floating(tb_float), .i_ce_n(ce_in_n), .o_reset_n(outs[0]), .o_reset(outs[1]),
    .o_watchdog_fault_out(outs[2]), .o_undervoltage_n(outs[3]), .o_ce_n(outs[4]),
    .o_backup_active_flag(outs[5]), .o_powerfail_flag(outs[6]));
  // ======================================
  // Clock, external tick and hang guard
  initial
  begin
    forever #50 clk = ~clk;
  end
  // One tick every two cycles
  always @(posedge clk)
    tb_in <= ~tb_in;
  // Ceiling is about twice the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_total++;
      summarize();
    end
  end
  // ======================================
  // Scoreboard
  task automatic note(input string n, input int s, input logic e);
    name_q.push_back(n);
    sel_q.push_back(s);
    exp_q.push_back(e);
  endtask
  task automatic check(input string n, input logic seen, input logic exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %b seen %b", n, exp, seen);
    end
  endtask
  // Compare on the falling edge, when registered outputs have settled
  always @(negedge clk)
    while (sel_q.size() > 0)
      check(name_q.pop_front(), outs[sel_q.pop_front()], exp_q.pop_front());
  task automatic summarize();
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait on settled outputs; a miss shows up in the following note
  task automatic wait_for(input int s, input logic v, input int lim);
    int i = 0;
    @(negedge clk);
    while (i < lim && outs[s] !== v)
    begin
      @(negedge clk);
      i++;
    end
    @(posedge clk);
  endtask
  // ======================================
  // Main sequence
  initial
  begin
    void'($urandom(84915));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cycles(4);
    note("reset_n", 0, 1'b0);
    note("reset", 1, 1'b1);
    note("undervoltage", 3, 1'b0);
    sup_ok <= 1'b1;
    cycles(4);
    note("undervoltage", 3, 1'b1);
    note("backup", 5, 1'b0);
    cycles(3990);
    note("reset_n", 0, 1'b0);
    wait_for(0, 1'b1, 300);
    note("reset_n", 0, 1'b1);
    note("reset", 1, 1'b0);
    // Comparator levels are random and must not disturb reset
    repeat (6)
    begin
      pf_low <= 1'($urandom);
      cycles(5);
      note("powerfail", 6, ~pf_low);
      note("reset_n", 0, 1'b1);
    end
    // Host stops: fault and reset after the normal period
    cycles(200);
    run <= 1'b0;
    cycles(1900);
    note("fault", 2, 1'b1);
    wait_for(2, 1'b0, 400);
    note("fault", 2, 1'b0);
    note("reset_n", 0, 1'b0);
    cycles(4000);
    note("fault", 2, 1'b0);
    note("reset_n", 0, 1'b0);
    wait_for(0, 1'b1, 300);
    note("reset_n", 0, 1'b1);
    // Still stuck: the longer after-reset period, then another pulse
    cycles(8000);
    note("reset_n", 0, 1'b1);
    wait_for(0, 1'b0, 600);
    note("reset_n", 0, 1'b0);
    note("fault", 2, 1'b0);
    run <= 1'b1;
    wait_for(0, 1'b1, 4400);
    cycles(100);
    note("fault", 2, 1'b1);
    // Floating activity input disables the watchdog
    mid <= 1'b1;
    cycles(10000);
    note("fault", 2, 1'b1);
    note("reset_n", 0, 1'b1);
    // Internal oscillator: a stuck host outlives the external timeout
    mid <= 1'b0;
    run <= 1'b0;
    tb_sel <= 1'b1;
    tb_float <= 1'($urandom);
    cycles(5000);
    note("fault", 2, 1'b1);
    note("reset_n", 0, 1'b1);
    // Supply loss with the memory selected
    tb_sel <= 1'b0;
    run <= 1'b1;
    ce_req <= 1'b1;
    cycles(5);
    note("ce_n", 4, 1'b0);
    sup_ok <= 1'b0;
    main_hi <= 1'b0;
    cycles(6);
    note("reset_n", 0, 1'b0);
    note("undervoltage", 3, 1'b0);
    note("backup", 5, 1'b1);
    note("fault", 2, 1'b1);
    cycles(100);
    note("ce_n", 4, 1'b0);
    cycles(100);
    note("ce_n", 4, 1'b1);
    // Second loss: select released early, gate stays blocked
    sup_ok <= 1'b1;
    main_hi <= 1'b1;
    wait_for(0, 1'b1, 4400);
    cycles(2);
    sup_ok <= 1'b0;
    cycles(20);
    ce_req <= 1'b0;
    cycles(6);
    ce_req <= 1'b1;
    cycles(6);
    note("ce_n", 4, 1'b1);
    cycles(2);
    summarize();
  end
endmodule
